// file: rtl/sop_program_port.sv
`timescale 1ns/100ps
module sop_program_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic prog_clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic program_high_level,
  input wire logic program_access_level,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  output logic cascade_enable_out,
  output logic prog_mode
);
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [sop_pkg::WORD_W-1:0] mem_ff [0:sop_pkg::ARRAY_WORDS];
  sop_pkg::sop_state_e state_ff;
  sop_pkg::sop_state_e nxt_state;
  logic pclk_q_ff;
  logic vpp_q_ff;
  logic [sop_pkg::ADDR_W-1:0] addr_ff;
  logic [sop_pkg::BIT_W-1:0] bit_ff;
  logic [sop_pkg::WORD_W-1:0] latch_ff;
  logic dout_ff;
  logic last_ff;
  logic end_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire pedge = prog_clk & ~pclk_q_ff;
  wire in_prog = (state_ff == sop_pkg::SOP_PROG);
  wire shift_in = in_prog & ce_n & oe_n;
  wire shift_out = in_prog & ~ce_n & oe_n;
  wire advance = in_prog & ce_n & ~oe_n;
  wire commit = in_prog & program_high_level & ~vpp_q_ff;
  wire hv_edge = pedge & ce_n & oe_n & program_high_level;
  wire acc_edge = pedge & ce_n & oe_n & program_access_level & ~program_high_level;
  wire [sop_pkg::WORD_W-1:0] rd_word = mem_ff[addr_ff];
  wire rd_bit = rd_word[sop_pkg::BIT_LAST - bit_ff];
  // all ones or erased means active high
  wire polarity_high = (mem_ff[sop_pkg::ADDR_OVERFLOW] != sop_pkg::POL_ACTIVE_LOW);
  wire last_read = pedge & shift_out & (addr_ff == sop_pkg::ADDR_LAST) &
                   (bit_ff == sop_pkg::BIT_LAST);
  wire [sop_pkg::BIT_W-1:0] bit_inc = bit_ff + 5'h01;
  wire [sop_pkg::ADDR_W-1:0] addr_inc = (addr_ff == sop_pkg::ADDR_OVERFLOW) ?
                                        addr_ff : addr_ff + 12'h001;

  // ----------------------------------------------------------------
  // mode entry
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sop_pkg::SOP_IDLE: begin
        if (hv_edge) begin
          nxt_state = sop_pkg::SOP_HV1;
        end
      end
      sop_pkg::SOP_HV1: begin
        if (pedge) begin
          nxt_state = hv_edge ? sop_pkg::SOP_HV2 : sop_pkg::SOP_IDLE;
        end
      end
      sop_pkg::SOP_HV2: begin
        if (acc_edge) begin
          nxt_state = sop_pkg::SOP_PROG;
        end else if (pedge && !hv_edge) begin
          nxt_state = sop_pkg::SOP_IDLE;
        end
      end
      sop_pkg::SOP_PROG: begin
        nxt_state = sop_pkg::SOP_PROG;
      end
      default: begin
        nxt_state = sop_pkg::SOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= sop_pkg::SOP_IDLE;
      pclk_q_ff <= 1'b0;
      vpp_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pclk_q_ff <= prog_clk;
      vpp_q_ff <= program_high_level;
    end
  end

  // ----------------------------------------------------------------
  // counters and shifting
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !in_prog) begin
      addr_ff <= sop_pkg::ADDR_FIRST;
      bit_ff <= sop_pkg::BIT_FIRST;
      latch_ff <= sop_pkg::LATCH_RST;
      dout_ff <= 1'b0;
    end else if (pedge) begin
      if (advance) begin
        addr_ff <= addr_inc;
        bit_ff <= sop_pkg::BIT_FIRST;
      end else if (shift_in) begin
        latch_ff <= {latch_ff[sop_pkg::WORD_W-2:0], data_in};
      end else if (shift_out) begin
        dout_ff <= rd_bit;
        bit_ff <= bit_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // end of array on cascade output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !in_prog) begin
      last_ff <= 1'b0;
      end_ff <= 1'b0;
    end else if (pedge) begin
      // low on the edge after last bit
      last_ff <= last_read;
      end_ff <= (end_ff & ~advance) | last_ff;
    end
  end

  // ----------------------------------------------------------------
  // array commit, otp bits only clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i <= sop_pkg::ARRAY_WORDS; i++) begin
        mem_ff[i] <= sop_pkg::WORD_ERASED;
      end
    end else if (commit) begin
      mem_ff[addr_ff] <= mem_ff[addr_ff] & latch_ff;
    end
  end

  // data pin driven only while shifting out
  assign data_out = dout_ff;
  assign data_oe = shift_out;
  assign cascade_enable_out = polarity_high & ~end_ff;
  assign prog_mode = in_prog;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helper: last array bit read, waiting for the next programmer edge
  logic chk_last_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || !in_prog) begin
      chk_last_ff <= 1'b0;
    end else if (pedge) begin
      chk_last_ff <= last_read;
    end
  end

  sequence s_end_edge;
    pedge && in_prog && chk_last_ff;
  endsequence

  sequence s_access_step;
    acc_edge && (state_ff == sop_pkg::SOP_HV2);
  endsequence

  chk_out_bit_value: assert property (@(posedge clk) disable iff (sys_rst)
    (pedge && shift_out && !advance) |=> (data_out == $past(rd_bit)))
    else $error("shifted out bit wrong");
  chk_one_bit_edge: assert property (@(posedge clk) disable iff (sys_rst)
    (in_prog && !pedge && !commit) |=> ($stable(latch_ff) && $stable(bit_ff)))
    else $error("bit moved without clock edge");
  chk_shift_in_bit: assert property (@(posedge clk) disable iff (sys_rst)
    (pedge && shift_in) |=> (latch_ff[0] == $past(data_in)) &&
      (latch_ff[31:1] == $past(latch_ff[30:0])))
    else $error("shift in failed");
  chk_counter_step: assert property (@(posedge clk) disable iff (sys_rst)
    (pedge && advance && addr_ff != sop_pkg::ADDR_OVERFLOW) |=>
      (addr_ff == $past(addr_ff) + 12'h001) && (bit_ff == sop_pkg::BIT_FIRST))
    else $error("word counter did not step");
  chk_counter_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (in_prog && !(pedge && advance)) |=> $stable(addr_ff))
    else $error("word counter moved");
  chk_fixed_sense: assert property (@(posedge clk) disable iff (sys_rst)
    in_prog |-> (data_oe == (!ce_n && oe_n)))
    else $error("oe sense not fixed");
  chk_polarity_out: assert property (@(posedge clk) disable iff (sys_rst)
    !end_ff |-> (cascade_enable_out ==
      (mem_ff[sop_pkg::ADDR_OVERFLOW] != sop_pkg::POL_ACTIVE_LOW)))
    else $error("cascade output not polarity");
  chk_end_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_edge |=> !cascade_enable_out)
    else $error("cascade output not low after last bit");
  chk_entry_done: assert property (@(posedge clk) disable iff (sys_rst)
    s_access_step |=> in_prog)
    else $error("access edge did not enter programming mode");
  chk_entry_seq: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(in_prog) |-> $past(acc_edge) && $past(state_ff == sop_pkg::SOP_HV2))
    else $error("entry without access edge");
  chk_entry_start: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(in_prog) |-> (addr_ff == sop_pkg::ADDR_FIRST) && (bit_ff == sop_pkg::BIT_FIRST))
    else $error("counter not at zero on entry");
  chk_commit_word: assert property (@(posedge clk) disable iff (sys_rst)
    commit |=> (mem_ff[$past(addr_ff)] == ($past(rd_word) & $past(latch_ff))))
    else $error("commit did not store word");
endmodule

// file: common/sop_pkg.sv
package sop_pkg;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ARRAY_WORDS = 2048;
  localparam int ADDR_W = 12;
  localparam int BIT_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 12'h7FF;
  localparam logic [ADDR_W-1:0] ADDR_OVERFLOW = 12'h800;
  localparam logic [BIT_W-1:0] BIT_FIRST = 5'h00;
  localparam logic [BIT_W-1:0] BIT_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // reset values and polarity codes
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_ERASED = 32'hFFFFFFFF;
  localparam logic [WORD_W-1:0] POL_ACTIVE_LOW = 32'h00000000;
  localparam logic [WORD_W-1:0] LATCH_RST = 32'h00000000;
  localparam int HV_EDGES = 2;

  // ----------------------------------------------------------------
  // mode entry states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SOP_IDLE = 4'h1,
    SOP_HV1 = 4'h2,
    SOP_HV2 = 4'h4,
    SOP_PROG = 4'h8
  } sop_state_e;
endpackage

// file: testbench/sop_prog_model.sv
`timescale 1ns/100ps
module sop_prog_model (
  input wire logic clk,
  output logic prog_clk,
  output logic ce_n,
  output logic oe_n,
  output logic program_high_level,
  output logic program_access_level,
  output logic data_in
);
  initial begin
    {prog_clk, ce_n, oe_n, program_high_level, data_in} = 5'h1D;
    program_access_level = 1'h1;
    prog_clk = 1'h0;
  end
  task automatic rise(input logic c, o, h, a, d);
    if (ce_n !== c) begin
      oe_n <= 1'h1;
      repeat (26) @(posedge clk);
      ce_n <= c;
      repeat (26) @(posedge clk);
    end
    if (oe_n !== o) begin
      oe_n <= o;
      repeat (26) @(posedge clk);
    end
    @(posedge clk);
    program_high_level <= h;
    program_access_level <= a;
    data_in <= d;
    prog_clk <= 1'h1;
    repeat (2) @(posedge clk);
    prog_clk <= 1'h0;
    data_in <= ~d;
    repeat (2) @(posedge clk);
  endtask
  // two high edges, one access edge
  task automatic enter();
    rise(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    rise(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    rise(1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
  endtask
  task automatic commit();
    @(posedge clk);
    program_high_level <= 1'h1;
    repeat (4) @(posedge clk);
    program_high_level <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  // both enables low: oe_n high, ce_n low, then oe_n low
  task automatic leave();
    oe_n <= 1'h1;
    repeat (26) @(posedge clk);
    ce_n <= 1'h0;
    repeat (26) @(posedge clk);
    oe_n <= 1'h0;
    repeat (26) @(posedge clk);
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk;
  logic sys_rst;
  wire pc, ce, oe, hi, ac, din;
  logic data_out, data_oe, cascade_enable_out, prog_mode;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] w;
  wire data_pin = data_oe ? data_out : din;
  sop_prog_model m (.clk(clk), .prog_clk(pc), .ce_n(ce), .oe_n(oe),
    .program_high_level(hi), .program_access_level(ac), .data_in(din));
  sop_program_port dut (.clk(clk), .sys_rst(sys_rst), .prog_clk(pc), .ce_n(ce),
    .oe_n(oe), .program_high_level(hi), .program_access_level(ac),
    .data_in(data_pin), .data_out(data_out), .data_oe(data_oe),
    .cascade_enable_out(cascade_enable_out), .prog_mode(prog_mode));
  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    forever #4 clk = ~clk;
  end
  task automatic chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
  endtask
  task automatic advance(input int n);
    for (int i = 0; i < n; i++) m.rise(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
  endtask
  task automatic read_word();
    for (int i = 0; i < 32; i++) begin
      m.rise(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
      chk1(data_oe, 1'h1);
      w = {w[30:0], data_out};
    end
  endtask
  task automatic write_word(input logic [31:0] v);
    for (int i = 0; i < 32; i++) m.rise(1'h1, 1'h1, 1'h0, 1'h1, v[31-i]);
    m.commit();
  endtask
  task automatic t_entry();
    do_reset();
    chk1(prog_mode, 1'h0);
    chk1(cascade_enable_out, 1'h1);
    m.enter();
    chk1(prog_mode, 1'h1);
  endtask
  task automatic t_words();
    write_word(32'hA5C30F96);
    chk1(data_oe, 1'h0);
    read_word();
    chkw(w, 32'hA5C30F96);
    advance(1);
    read_word();
    chkw(w, sop_pkg::WORD_ERASED);
  endtask
  task automatic t_polarity();
    advance(2047);
    read_word();
    chkw(w, sop_pkg::WORD_ERASED);
    write_word(sop_pkg::POL_ACTIVE_LOW);
    chk1(cascade_enable_out, 1'h0);
    read_word();
    chkw(w, sop_pkg::POL_ACTIVE_LOW);
  endtask
  task automatic t_end_array();
    m.leave();
    chk1(data_oe, 1'h0);
    do_reset();
    chk1(prog_mode, 1'h0);
    chk1(cascade_enable_out, 1'h1);
    m.enter();
    advance(2047);
    read_word();
    chk1(cascade_enable_out, 1'h1);
    m.rise(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    chk1(cascade_enable_out, 1'h0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_entry();
    t_words();
    t_polarity();
    t_end_array();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
